// ===== rtl/mb_slave_pkg.sv
/*
  Shared constants, types and helper functions for the serial-line holding register slave.
  Assumes a single 50 MHz system clock and a byte-level UART outside the block.
*/
package mb_slave_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: frame gap is three and a half character times at the default rate
  localparam longint CLK_HZ = 50_000_000;
  localparam longint BAUD_DEFAULT = 38400;
  localparam longint CHAR_BITS = 11;
  localparam longint GAP_HALF_CHARS = 7;
  localparam int GAP_CYCLES = int'((GAP_HALF_CHARS * CHAR_BITS * CLK_HZ + 2 * BAUD_DEFAULT - 1) / (2 * BAUD_DEFAULT));
  localparam int GAP_W = 17;

  ////////////////////////////////////////////////////////////////////////////
  // Function codes, exception codes and slave address range
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE1 = 8'h06;
  localparam logic [7:0] FC_WRITEN = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hF7;

  ////////////////////////////////////////////////////////////////////////////
  // Register map: data address = holding register number - 40001
  localparam logic [15:0] HOLDING_BASE = 16'h9C41;
  localparam logic [15:0] HIGHEST_DATA_ADDRESS = 16'h0094;
  localparam int NUM_REGS = int'(HIGHEST_DATA_ADDRESS) + 1;
  localparam logic [7:0] IDX_SLAVE_ADDR = 8'h00;
  localparam logic [7:0] IDX_BAUD = 8'h01;
  localparam logic [7:0] IDX_PARITY = 8'h02;
  localparam logic [7:0] IDX_ALARM_LO = 8'h2C;
  localparam logic [7:0] IDX_ALARM_HI = 8'h2D;
  localparam logic [7:0] IDX_CHEM = 8'h40;
  localparam logic [7:0] IDX_VSEL = 8'h41;
  localparam logic [15:0] SLAVE_ADDR_RST = 16'h0001;
  localparam logic [15:0] BAUD_RST = 16'h0003;
  localparam logic [15:0] PARITY_RST = 16'h0002;

  ////////////////////////////////////////////////////////////////////////////
  // Frame sizes in bytes
  localparam int MAX_N = 16;
  localparam int BUF_LEN = 9 + 2 * MAX_N;
  localparam logic [5:0] MIN_LEN = 6'h04;
  localparam logic [5:0] FIXED_LEN = 6'h08;
  localparam logic [5:0] MULTI_OVH = 6'h09;
  localparam logic [5:0] READ_OVH = 6'h05;
  localparam logic [5:0] EXC_LEN = 6'h05;
  localparam logic [5:0] DATA_POS = 6'h07;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  typedef struct packed {
    logic [7:0] idx;
    logic [15:0] data;
  } reg_wr_t;

  typedef struct packed {
    logic [15:0] baud;
    logic [15:0] parity;
  } ser_cfg_t;

  // Registers the bus may write; status, chemistry and voltage selection never
  function automatic logic writable(input logic [7:0] idx);
    return (32'(idx) < NUM_REGS) && !(idx inside {IDX_ALARM_LO, IDX_ALARM_HI, IDX_CHEM, IDX_VSEL});
  endfunction

  function automatic logic [15:0] rst_val(input int i);
    return (i == 0) ? SLAVE_ADDR_RST : (i == 1) ? BAUD_RST : (i == 2) ? PARITY_RST : 16'h0000;
  endfunction

endpackage

// ===== rtl/crc16_byte.sv
/*
  Byte-wide serial-line CRC accumulator, reflected polynomial, all-ones start.
  Assumes the caller clears it before each frame and feeds one byte per enable.
*/
`timescale 1ns/10ps
module crc16_byte (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Control and data
  input wire logic clear_i,
  input wire logic en_i,
  input wire logic [7:0] data_i,
  // Result
  output logic [15:0] crc_o,
  output logic [15:0] crc_nxt_o
);

  // Eight shift steps per byte, LSB first
  always_comb begin
    crc_nxt_o = crc_o ^ {8'h00, data_i};
    for (int b = 0; b < 8; b++) begin
      crc_nxt_o = crc_nxt_o[0] ? ((crc_nxt_o >> 1) ^ mb_slave_pkg::CRC_POLY) : (crc_nxt_o >> 1);
    end
  end

  // Clear wins so a new frame never inherits state
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc_o <= mb_slave_pkg::CRC_INIT;
    end else if (clear_i) begin
      crc_o <= mb_slave_pkg::CRC_INIT;
    end else if (en_i) begin
      crc_o <= crc_nxt_o;
    end
  end

endmodule

// ===== rtl/hreg_store.sv
/*
  Holding register storage with read-only overlays for alarms and selections.
  Assumes writes arrive already validated; the voltage strap comes from a pin.
*/
`timescale 1ns/10ps
module hreg_store (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Write and read port
  input wire logic wr_en_i,
  input wire mb_slave_pkg::reg_wr_t wr_i,
  input wire logic [7:0] rd_idx_i,
  output logic [15:0] rd_data_o,
  // Device status and selections
  input wire logic [31:0] alarm_i,
  input wire logic [15:0] chem_sel_i,
  input wire logic [15:0] vsel_pin_i,
  // Configuration out
  output logic [7:0] slave_addr_o,
  output mb_slave_pkg::ser_cfg_t ser_cfg_o
);

  logic [15:0] hreg_r [mb_slave_pkg::NUM_REGS];
  logic [15:0] vsel_s1_r;
  logic [15:0] vsel_s2_r;
  logic [15:0] vsel_r;
  logic [1:0] vsel_cnt_r;
  logic cfg_done_r;

  ////////////////////////////////////////////////////////////////////////////
  // One word per entry; protected entries simply never take a write
  for (genvar g = 0; g < mb_slave_pkg::NUM_REGS; g++) begin : g_word
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        hreg_r[g] <= mb_slave_pkg::rst_val(g);
      end else if (wr_en_i && wr_i.idx == 8'(g) && mb_slave_pkg::writable(8'(g))) begin
        hreg_r[g] <= wr_i.data;
      end
    end
  end

  // R17 strap sampled once, when the second stage first holds the pin
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vsel_s1_r <= 16'h0000;
      vsel_s2_r <= 16'h0000;
      vsel_r <= 16'h0000;
      vsel_cnt_r <= 2'h0;
    end else begin
      vsel_s1_r <= vsel_pin_i;
      vsel_s2_r <= vsel_s1_r;
      if (vsel_cnt_r != 2'h3) vsel_cnt_r <= vsel_cnt_r + 2'h1;
      if (vsel_cnt_r == 2'h2) vsel_r <= vsel_s2_r;
    end
  end

  // R18 R19 line settings load once after each reset, from the reset values; later writes never reach ser_cfg_o
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ser_cfg_o <= '0;
      cfg_done_r <= 1'b0;
    end else if (!cfg_done_r) begin
      ser_cfg_o <= '{baud: hreg_r[1], parity: hreg_r[2]};
      cfg_done_r <= 1'b1;
    end
  end

  // New slave address acts at once
  assign slave_addr_o = hreg_r[0][7:0];

  // Read mux, alarm bits read 1 while active
  always_comb begin
    rd_data_o = 16'h0000;
    if (32'(rd_idx_i) < mb_slave_pkg::NUM_REGS) begin
      unique case (rd_idx_i)
        mb_slave_pkg::IDX_ALARM_LO: rd_data_o = alarm_i[15:0];
        mb_slave_pkg::IDX_ALARM_HI: rd_data_o = alarm_i[31:16];
        mb_slave_pkg::IDX_CHEM: rd_data_o = chem_sel_i;
        mb_slave_pkg::IDX_VSEL: rd_data_o = vsel_r;
        default: rd_data_o = hreg_r[rd_idx_i];
      endcase
    end
  end

endmodule

// ===== rtl/mb_rtu_slave.sv
/*
  Serial-line holding register slave: frames requests, checks them, executes
  read / write single / write multiple and sends the reply or an exception.
  Assumes a UART outside that delivers received bytes as same-clock pulses and
  takes reply bytes with a valid/ready handshake.
*/
// Notes on behaviour
// R01 - Slave only; stays idle until a whole frame is received and checked.
// R02 - Unsupported function or bad address gives an exception code 1 or 2.
// R03 - A clean request is executed, then a normal reply is sent.
// R04 - Every parameter is a 16-bit unsigned holding register numbered from 40001.
// R05 - Alarm bits in holding registers read 1 while the alarm is active.
// R06 - Every accepted write is committed to non-volatile memory without a save command.
// R07 - Only function codes 3, 6 and 16 are served; others are illegal.
// R08 - Slave address in first byte lies between 1 and 247.
// R09 - Data address is register number minus 40001, up to the highest mapped.
// R10 - Read request: address, 3, start, count of one or more, CRC.
// R11 - Read reply: address, 3, byte count twice N, values high first, CRC.
// R12 - Exception reply: address, function with top bit set, code, CRC.
// R13 - Single write request: address, 6, data address, any 16-bit value, CRC.
// R14 - Single write reply echoes address, function, data address and value, new CRC.
// R15 - Multiple write: 16, start, N, byte count 2N, values; reply echoes start, N.
// R16 - Every frame ends in a two-byte CRC; failing frames are ignored.
// R17 - Writes to battery chemistry and output voltage selection are refused.
// R18 - Eight data bits; parity and stop settings; even parity at 38400 default.
// R19 - New slave address acts at once; line settings after power cycle (here each reset reloads the defaults, so written settings never apply).
// R20 - Frames end at 3.5 character silence; foreign or partial frames get no reply.
// R21 - CRC reflected 0xA001 from all ones, low byte first; fields high first.
`timescale 1ns/10ps
module mb_rtu_slave #(
  parameter int GAP_CYCLES = mb_slave_pkg::GAP_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Received bytes from the UART
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic rx_err_i,
  // Reply bytes to the UART
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic tx_en_o,
  // Device status and selections
  input wire logic [31:0] alarm_i,
  input wire logic [15:0] chem_sel_i,
  input wire logic [15:0] vsel_pin_i,
  // Non-volatile commit and configuration
  output logic nv_wr_o,
  output mb_slave_pkg::reg_wr_t nv_wr_data_o,
  output mb_slave_pkg::ser_cfg_t ser_cfg_o,
  output logic [7:0] slave_addr_o
);

  typedef enum logic [2:0] {S_RX, S_CHECK, S_WCHK, S_WRITE, S_TX} state_t;

  state_t state_r;
  state_t state_nxt;
  logic [7:0] buf_r [mb_slave_pkg::BUF_LEN];
  logic [5:0] rx_cnt_r;
  logic bad_r;
  logic [mb_slave_pkg::GAP_W-1:0] idle_cnt_r;
  logic [7:0] exc_r;
  logic [4:0] w_idx_r;
  logic [5:0] tx_idx_r;
  logic [7:0] tx_data_r;
  logic tx_valid_r;
  logic tx_en_r;
  logic nv_wr_r;
  mb_slave_pkg::reg_wr_t nv_data_r;
  logic [7:0] fc;
  logic [15:0] start;
  logic [15:0] qty;
  logic [4:0] n_regs;
  logic range_ok;
  logic frame_ok;
  logic frame_end;
  logic [7:0] chk_exc;
  logic [15:0] rx_crc;
  logic [15:0] tx_crc;
  logic [15:0] tx_crc_nxt;
  logic [15:0] rd_data;
  logic [7:0] rd_idx;
  logic [5:0] tx_sel;
  logic [5:0] tx_len;
  logic [7:0] tx_byte;
  logic tx_hs;
  logic [5:0] dpos;
  mb_slave_pkg::reg_wr_t wr;
  logic wr_en;

  ////////////////////////////////////////////////////////////////////////////
  // Request fields, always read from the frame buffer
  assign fc = buf_r[1];
  assign start = {buf_r[2], buf_r[3]};
  assign qty = {buf_r[4], buf_r[5]};
  assign n_regs = (fc == mb_slave_pkg::FC_WRITE1) ? 5'h01 : qty[4:0];
  assign tx_hs = tx_valid_r && tx_ready_i;
  // R09 address range
  assign range_ok = qty != 16'h0000 && qty <= 16'(mb_slave_pkg::MAX_N)
                    && (17'(start) + 17'(qty)) <= 17'(mb_slave_pkg::NUM_REGS);
  // R16 R08 accept gate
  assign frame_ok = !bad_r && rx_cnt_r >= mb_slave_pkg::MIN_LEN && rx_crc == 16'h0000
                    && buf_r[0] == slave_addr_o && slave_addr_o >= mb_slave_pkg::ADDR_MIN
                    && slave_addr_o <= mb_slave_pkg::ADDR_MAX;
  // R20 silence closes a frame
  assign frame_end = state_r == S_RX && (rx_cnt_r != 6'h00 || bad_r) && !rx_valid_i
                     && idle_cnt_r == mb_slave_pkg::GAP_W'(GAP_CYCLES - 1);

  // Request checks; a malformed length counts as a bad address
  always_comb begin
    chk_exc = mb_slave_pkg::EXC_NONE;
    case (fc)
      // R10 read request
      mb_slave_pkg::FC_READ: begin
        if (rx_cnt_r != mb_slave_pkg::FIXED_LEN || !range_ok) chk_exc = mb_slave_pkg::EXC_ILL_ADDR;
      end
      // R13 single write request
      mb_slave_pkg::FC_WRITE1: begin
        if (rx_cnt_r != mb_slave_pkg::FIXED_LEN || 32'(start) >= mb_slave_pkg::NUM_REGS) begin
          chk_exc = mb_slave_pkg::EXC_ILL_ADDR;
        end
      end
      // R15 multiple write request
      mb_slave_pkg::FC_WRITEN: begin
        if (!range_ok || buf_r[6] != {qty[6:0], 1'b0}
            || 17'(rx_cnt_r) != 17'(mb_slave_pkg::MULTI_OVH) + {qty, 1'b0}) begin
          chk_exc = mb_slave_pkg::EXC_ILL_ADDR;
        end
      end
      // R07 R02 anything else
      default: chk_exc = mb_slave_pkg::EXC_ILL_FUNC;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      // R01 wait for a whole frame
      S_RX: if (frame_end) state_nxt = S_CHECK;
      S_CHECK: begin
        if (!frame_ok) state_nxt = S_RX;
        else if (chk_exc != mb_slave_pkg::EXC_NONE || fc == mb_slave_pkg::FC_READ) state_nxt = S_TX;
        else state_nxt = S_WCHK;
      end
      // R17 all targets must be writable before any is touched
      S_WCHK: begin
        if (!mb_slave_pkg::writable(wr.idx)) state_nxt = S_TX;
        else if (w_idx_r == n_regs - 5'h01) state_nxt = S_WRITE;
      end
      S_WRITE: if (w_idx_r == n_regs - 5'h01) state_nxt = S_TX;
      S_TX: if (tx_hs && tx_idx_r == tx_len - 6'h01) state_nxt = S_RX;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) state_r <= S_RX;
    else state_r <= state_nxt;
  end

  // Receive buffer; bytes during a reply are dropped (half duplex)
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_cnt_r <= 6'h00;
      bad_r <= 1'b0;
      for (int i = 0; i < mb_slave_pkg::BUF_LEN; i++) buf_r[i] <= 8'h00;
    end else if (state_r != S_RX) begin
      if (state_nxt == S_RX) begin
        rx_cnt_r <= 6'h00;
        bad_r <= 1'b0;
      end
    end else if (rx_valid_i) begin
      // R20 overlong or damaged frames are discarded later
      if (32'(rx_cnt_r) == mb_slave_pkg::BUF_LEN || rx_err_i) begin
        bad_r <= 1'b1;
      end else begin
        buf_r[rx_cnt_r] <= rx_data_i;
        rx_cnt_r <= rx_cnt_r + 6'h01;
      end
    end
  end

  // Line silence counter
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) idle_cnt_r <= '0;
    else if (state_r != S_RX || rx_valid_i) idle_cnt_r <= '0;
    else if (idle_cnt_r != mb_slave_pkg::GAP_W'(GAP_CYCLES - 1)) idle_cnt_r <= idle_cnt_r + 1'b1;
  end

  // Exception code, held until the next frame is checked
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) exc_r <= mb_slave_pkg::EXC_NONE;
    else if (state_r == S_CHECK) exc_r <= chk_exc;
    else if (state_r == S_WCHK && !mb_slave_pkg::writable(wr.idx)) exc_r <= mb_slave_pkg::EXC_ILL_ADDR;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write loop: check pass, then commit pass
  assign dpos = (fc == mb_slave_pkg::FC_WRITE1) ? 6'h04 : mb_slave_pkg::DATA_POS + {w_idx_r, 1'b0};
  assign wr = '{idx: start[7:0] + 8'(w_idx_r), data: {buf_r[dpos], buf_r[dpos + 6'h01]}};
  assign wr_en = state_r == S_WRITE;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) w_idx_r <= 5'h00;
    else if (state_nxt != state_r) w_idx_r <= 5'h00;
    else if (state_r == S_WCHK || state_r == S_WRITE) w_idx_r <= w_idx_r + 5'h01;
  end

  // R06 commit strobe to non-volatile memory
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nv_wr_r <= 1'b0;
      nv_data_r <= '0;
    end else begin
      nv_wr_r <= wr_en;
      if (wr_en) nv_data_r <= wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply assembly
  assign tx_sel = (state_r == S_TX) ? tx_idx_r + 6'h01 : 6'h00;
  assign tx_len = (exc_r != mb_slave_pkg::EXC_NONE) ? mb_slave_pkg::EXC_LEN
                : (fc == mb_slave_pkg::FC_READ) ? mb_slave_pkg::READ_OVH + {qty[4:0], 1'b0}
                : mb_slave_pkg::FIXED_LEN;
  assign rd_idx = start[7:0] + {3'b000, 5'((tx_sel - 6'h03) >> 1)};

  always_comb begin
    tx_byte = 8'h00;
    // R21 CRC low byte then high byte
    if (tx_sel == tx_len - 6'h02) tx_byte = tx_crc_nxt[7:0];
    else if (tx_sel == tx_len - 6'h01) tx_byte = tx_crc[15:8];
    else if (tx_sel == 6'h00) tx_byte = buf_r[0];
    // R12 flagged function code
    else if (tx_sel == 6'h01) tx_byte = (exc_r != mb_slave_pkg::EXC_NONE) ? (fc | mb_slave_pkg::EXC_FLAG) : fc;
    else if (exc_r != mb_slave_pkg::EXC_NONE) tx_byte = exc_r;
    // R11 byte count then values high first
    else if (fc == mb_slave_pkg::FC_READ) tx_byte = (tx_sel == 6'h02) ? {qty[6:0], 1'b0}
                                                  : (tx_sel[0] ? rd_data[15:8] : rd_data[7:0]);
    // R14 R15 echo of address and value or count
    else tx_byte = buf_r[tx_sel];
  end

  // R03 reply path and driver enable
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_idx_r <= 6'h00;
      tx_data_r <= 8'h00;
      tx_valid_r <= 1'b0;
      tx_en_r <= 1'b0;
    end else if (state_r != S_TX && state_nxt == S_TX) begin
      tx_idx_r <= 6'h00;
      tx_data_r <= tx_byte;
      tx_valid_r <= 1'b1;
      tx_en_r <= 1'b1;
    end else if (tx_hs) begin
      tx_idx_r <= tx_sel;
      tx_data_r <= tx_byte;
      tx_valid_r <= state_nxt == S_TX;
      tx_en_r <= state_nxt == S_TX;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CRC engines and register storage
  crc16_byte u_rx_crc (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clear_i(state_r != S_RX),
    .en_i(state_r == S_RX && rx_valid_i), .data_i(rx_data_i), .crc_o(rx_crc), .crc_nxt_o()
  );

  crc16_byte u_tx_crc (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clear_i(state_r != S_TX),
    .en_i(tx_hs && tx_idx_r < tx_len - 6'h02), .data_i(tx_data_r), .crc_o(tx_crc), .crc_nxt_o(tx_crc_nxt)
  );

  // R04 R05 R19 word store with status overlays
  hreg_store u_store (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en), .wr_i(wr), .rd_idx_i(rd_idx),
    .rd_data_o(rd_data), .alarm_i(alarm_i), .chem_sel_i(chem_sel_i), .vsel_pin_i(vsel_pin_i),
    .slave_addr_o(slave_addr_o), .ser_cfg_o(ser_cfg_o)
  );

  assign tx_data_o = tx_data_r;
  assign tx_valid_o = tx_valid_r;
  assign tx_en_o = tx_en_r;
  assign nv_wr_o = nv_wr_r;
  assign nv_wr_data_o = nv_data_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  tx_only_reply_a: assert property (tx_valid_r |-> state_r == S_TX) // R03
    else $error("reply byte outside reply state");
  exc_code_legal_a: assert property (state_r == S_TX |-> exc_r inside {8'h00, 8'h01, 8'h02}) // R02
    else $error("exception code out of range");
  commit_after_write_a: assert property (nv_wr_r |-> $past(state_r) == S_WRITE) // R06
    else $error("commit without a write step");
  protected_never_written_a: assert property (nv_wr_r |-> mb_slave_pkg::writable(nv_data_r.idx)) // R17
    else $error("protected register written");
  bad_crc_dropped_a: assert property (state_r == S_CHECK && rx_crc != 16'h0000 |=> state_r == S_RX) // R16
    else $error("frame with bad CRC acted on");
  foreign_addr_dropped_a: assert property (state_r == S_CHECK && buf_r[0] != slave_addr_o |=> state_r == S_RX) // R20
    else $error("foreign frame answered");
  illegal_func_a: assert property (state_r == S_CHECK && frame_ok && !(fc inside {8'h03, 8'h06, 8'h10}) // R07
    |=> state_r == S_TX && exc_r == 8'h01)
    else $error("illegal function not flagged");
  exc_func_flag_a: assert property (tx_valid_r && tx_idx_r == 6'h01 && exc_r != 8'h00 // R12
    |-> tx_data_r == (fc | 8'h80))
    else $error("exception function code not flagged");
  gap_before_check_a: assert property ($rose(state_r == S_CHECK) // R20
    |-> $past(idle_cnt_r) == mb_slave_pkg::GAP_W'(GAP_CYCLES - 1))
    else $error("frame closed without silence");
  read_count_a: assert property (tx_valid_r && tx_idx_r == 6'h02 && exc_r == 8'h00 && fc == 8'h03 // R11
    |-> tx_data_r == {qty[6:0], 1'b0})
    else $error("read byte count wrong");
  crc_high_last_a: assert property (tx_valid_r && tx_idx_r == tx_len - 6'h01 |-> tx_data_r == tx_crc[15:8]) // R21
    else $error("last reply byte is not CRC high");

  read_reply_c: cover property (state_r == S_TX && exc_r == 8'h00 && fc == 8'h03 ##1 state_r == S_RX);
  multi_write_c: cover property (nv_wr_r && fc == 8'h10 ##1 nv_wr_r);
  exception_c: cover property (state_r == S_TX && exc_r == 8'h02);
  dropped_frame_c: cover property (state_r == S_CHECK && !frame_ok);

endmodule

// ===== testbench/mb_master_model.sv
/*
  Far-side partner on the reply path: a UART that takes reply bytes, promptly or with stalls.
  Assumes the bench reads got_q and clears it before each request frame.
*/
`timescale 1ns/10ps
module mb_master_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Reply handshake
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  input wire logic tx_en_i,
  input wire logic slow_i,
  output logic tx_ready_o
);
  logic [7:0] got_q[$];
  logic [1:0] div_r;
  ////////////////////////////////////////////////////////////////////////////
  // Slow mode accepts one byte in four cycles so the reply must hold its byte
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r <= 2'h0;
      tx_ready_o <= 1'b0;
    end else begin
      div_r <= div_r + 2'h1;
      tx_ready_o <= !slow_i || (div_r == 2'h3);
    end
  end
  // keep wire order
  // A byte handed over with the line driver off never reaches the master
  always @(posedge sys_clk_i) begin
    if (tx_valid_i && tx_ready_o && tx_en_i) begin
      got_q.push_back(tx_data_i);
    end
  end
endmodule

// ===== testbench/modbus_rtu_holding_register_slave_tb_top.sv
/*
  Self-checking bench for the serial-line holding register slave.
  Assumes a short frame gap parameter and a byte-level UART in front of the block.
*/
`timescale 1ns/10ps
module modbus_rtu_holding_register_slave_tb_top;
  typedef logic [7:0] bq_t[$];
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] rx_data_i = 8'h00;
  logic rx_valid_i = 1'b0;
  logic [31:0] alarm_i = 32'hA5A5_0001;
  logic slow = 1'b0;
  logic rx_err = 1'b0;
  logic [15:0] vsel_pin = 16'h0018;
  logic [7:0] tx_data_o, slave_addr_o;
  logic tx_valid_o, tx_ready, tx_en_o, nv_wr_o;
  mb_slave_pkg::reg_wr_t nv_wr_data_o;
  mb_slave_pkg::ser_cfg_t ser_cfg_o;
  int n_mismatch = 0;
  int num_checks = 0;
  int nv_cnt = 0;
  mb_rtu_slave #(.GAP_CYCLES(20)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .rx_data_i(rx_data_i),
    .rx_valid_i(rx_valid_i), .rx_err_i(rx_err), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready), .tx_en_o(tx_en_o), .alarm_i(alarm_i), .chem_sel_i(16'h0007),
    .vsel_pin_i(vsel_pin), .nv_wr_o(nv_wr_o), .nv_wr_data_o(nv_wr_data_o), .ser_cfg_o(ser_cfg_o),
    .slave_addr_o(slave_addr_o));
  mb_master_model partner (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .tx_data_i(tx_data_o),
    .tx_valid_i(tx_valid_o), .tx_en_i(tx_en_o), .slow_i(slow), .tx_ready_o(tx_ready));
  always #10 sys_clk_i = ~sys_clk_i;
  // Count commits; a missed pulse shows up as a short count
  always @(posedge sys_clk_i) begin
    if (nv_wr_o === 1'b1) nv_cnt++;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] crc16(input bq_t q);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Send a request with its CRC (low byte first), await and compare the reply; empty exp means silence
  task automatic xfer(input bq_t req, input bq_t exp, input bit bad);
    logic [15:0] c;
    int n;
    c = crc16(req);
    req.push_back(c[7:0]);
    req.push_back(c[15:8] ^ {7'h00, bad});
    c = crc16(exp);
    if (exp.size() > 0) exp.push_back(c[7:0]);
    if (exp.size() > 0) exp.push_back(c[15:8]);
    partner.got_q.delete();
    foreach (req[i]) begin
      @(negedge sys_clk_i);
      rx_data_i = req[i];
      rx_valid_i = 1'b1;
      @(negedge sys_clk_i);
      rx_valid_i = 1'b0;
    end
    n = 0;
    while (n < 600 && !(partner.got_q.size() > 0 && tx_en_o === 1'b0)) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n == 600 && exp.size() > 0) begin
      chk(16'h0000, 16'h0001, "reply timeout");
      print_verdict();
    end
    chk(16'(partner.got_q.size()), 16'(exp.size()), "reply length");
    foreach (exp[i]) if (i < partner.got_q.size()) chk({8'h00, partner.got_q[i]}, {8'h00, exp[i]}, "reply byte");
    repeat (26) @(negedge sys_clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_read();
    chk(ser_cfg_o.baud, mb_slave_pkg::BAUD_RST, "baud setting");
    chk(ser_cfg_o.parity, mb_slave_pkg::PARITY_RST, "parity setting");
    xfer('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h03, 8'h02, 8'h00, 8'h01}, 0);
    xfer('{8'h01, 8'h03, 8'h00, 8'h2C, 8'h00, 8'h02}, '{8'h01, 8'h03, 8'h04, 8'h00, 8'h01, 8'hA5, 8'hA5}, 0);
    $display("test read done");
  endtask
  task automatic t_write1();
    int n0;
    n0 = nv_cnt;
    slow = 1'b1;
    xfer('{8'h01, 8'h06, 8'h00, 8'h05, 8'hFF, 8'hFF}, '{8'h01, 8'h06, 8'h00, 8'h05, 8'hFF, 8'hFF}, 0);
    chk(16'(nv_cnt - n0), 16'h0001, "commit count");
    chk(nv_wr_data_o[15:0], 16'hFFFF, "commit value");
    chk({8'h00, nv_wr_data_o.idx}, 16'h0005, "commit index");
    slow = 1'b0;
    xfer('{8'h01, 8'h03, 8'h00, 8'h05, 8'h00, 8'h01}, '{8'h01, 8'h03, 8'h02, 8'hFF, 8'hFF}, 0);
    $display("test write single done");
  endtask
  task automatic t_multi();
    int n0;
    n0 = nv_cnt;
    xfer('{8'h01, 8'h10, 8'h00, 8'h10, 8'h00, 8'h02, 8'h04, 8'h12, 8'h34, 8'hAB, 8'hCD},
      '{8'h01, 8'h10, 8'h00, 8'h10, 8'h00, 8'h02}, 0);
    chk(16'(nv_cnt - n0), 16'h0002, "commit count");
    xfer('{8'h01, 8'h03, 8'h00, 8'h10, 8'h00, 8'h02}, '{8'h01, 8'h03, 8'h04, 8'h12, 8'h34, 8'hAB, 8'hCD}, 0);
    $display("test write multiple done");
  endtask
  task automatic t_except();
    int n0;
    n0 = nv_cnt;
    xfer('{8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h84, 8'h01}, 0);
    xfer('{8'h01, 8'h03, 8'h00, 8'h94, 8'h00, 8'h02}, '{8'h01, 8'h83, 8'h02}, 0);
    xfer('{8'h01, 8'h06, 8'h00, 8'h40, 8'h00, 8'h01}, '{8'h01, 8'h86, 8'h02}, 0);
    xfer('{8'h01, 8'h10, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00}, '{8'h01, 8'h90, 8'h02}, 0);
    chk(16'(nv_cnt - n0), 16'h0000, "refused commit");
    vsel_pin = 16'h0024;
    xfer('{8'h01, 8'h03, 8'h00, 8'h40, 8'h00, 8'h02}, '{8'h01, 8'h03, 8'h04, 8'h00, 8'h07, 8'h00, 8'h18}, 0);
    rx_err = 1'b1;
    xfer('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{}, 0);
    rx_err = 1'b0;
    xfer('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{}, 1);
    xfer('{8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{}, 0);
    $display("test exceptions done");
  endtask
  task automatic t_addr();
    xfer('{8'h01, 8'h06, 8'h00, 8'h00, 8'h00, 8'h02}, '{8'h01, 8'h06, 8'h00, 8'h00, 8'h00, 8'h02}, 0);
    chk({8'h00, slave_addr_o}, 16'h0002, "slave address");
    xfer('{8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h02, 8'h03, 8'h02, 8'h00, 8'h02}, 0);
    $display("test slave address done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    t_read();
    t_write1();
    t_multi();
    t_except();
    t_addr();
    print_verdict();
  end
endmodule
